// file: rtl/ivu_defines.svh
// constants of the interrupt vectoring unit: offsets, fields, resets, counts
// assumes inclusion by bare name from the package and the top module
`ifndef IVU_DEFINES_SVH
`define IVU_DEFINES_SVH

`define IVU_OFS_STATUS      8'h00
`define IVU_OFS_FLAG_EN     8'h04
`define IVU_OFS_FLAGS       8'h08
`define IVU_OFS_LEVEL_EN    8'h0c
`define IVU_OFS_STACK_PTR   8'h10
`define IVU_OFS_INFO        8'h14

`define IVU_GIE_BIT         7
`define IVU_NUM_FLAG        8
`define IVU_NUM_LEVEL       4
`define IVU_NUM_SRC         12
`define IVU_PC_W            12

`define IVU_RST_STATUS      8'h00
`define IVU_RST_FLAG_EN     8'h00
`define IVU_RST_LEVEL_EN    4'h0
`define IVU_RST_STACK_PTR   16'h0000
`define IVU_RESET_VECTOR    12'h000

`define IVU_ENTRY_CYC       4
`define IVU_SLEEP_EXTRA_CYC 4
`define IVU_JUMP_CYC        3
`define IVU_RETURN_CYC      4
`define IVU_SP_STEP         16'h0002

`define IVU_RESP_OKAY       2'b00
`define IVU_RESP_SLVERR     2'b10

`endif

// file: rtl/ivu_pkg.sv
// types shared by the interrupt vectoring unit and its neighbours
// assumes ivu_defines.svh is on the include path
`include "ivu_defines.svh"

package ivu_pkg;

	typedef enum logic [1:0] {
		IVU_INSN_OTHER = 2'b00,
		IVU_INSN_SEI   = 2'b01,
		IVU_INSN_CLI   = 2'b10,
		IVU_INSN_RETURN_FROM_IRQ_INSTRUCTION  = 2'b11
	} ivu_insn_t;

	typedef enum logic [1:0] {
		IVU_ST_IDLE   = 2'b00,
		IVU_ST_ENTRY  = 2'b01,
		IVU_ST_JUMP   = 2'b10,
		IVU_ST_RETURN = 2'b11
	} ivu_state_t;

	// sequencer report: instruction completion and what it was
	typedef struct packed {
		logic                    boundary;
		ivu_insn_t               kind;
		logic                    sleeping;
		logic [`IVU_PC_W-1:0]    next_pc;
	} ivu_seq_t;

	typedef struct packed {
		logic                    valid;
		logic [`IVU_PC_W-1:0]    addr;
	} ivu_pcload_t;

	typedef struct packed {
		logic                    we;
		logic                    re;
		logic [15:0]             addr;
		logic [7:0]              wdata;
	} ivu_stk_t;

endpackage

// file: rtl/ivu_top.sv
// interrupt vectoring unit: gating, priority, entry, return, stack push/pop
// assumes one clock, a synchronous-read stack memory, same-clock sources
// Function
// - take source only if own and global enable
// - lowest vector wins, reset highest
// - accepting an interrupt clears global enable
// - global enable set in handler allows nesting
// - return instruction sets global enable
// - flag source vectors and flag cleared by hardware
// - writing one clears a flag, zero keeps
// - disabled flag source stays latched until enabled
// - pending flags served by priority once enabled
// - level sources request only while present
// - one main instruction after return before service
// - disable instruction blocks even simultaneous interrupts
// - instruction after enable runs before interrupt
// - entry takes four cycles, pushing the counter
// - vector jump takes three cycles
// - multi-cycle instruction finishes before entry
// - sleep wake adds four entry cycles
// - return four cycles, pop two bytes
// - global enable sits at status bit 7
// - entry push lowers stack pointer by two
`timescale 1ns/1ps
`include "ivu_defines.svh"

module ivu_top
	import ivu_pkg::*;
(
	input  wire logic                       CLOCK,
	input  wire logic                       RSTN,
	input  wire logic [7:0]                 S_AXI_AWADDR,
	input  wire logic                       S_AXI_AWVALID,
	output wire logic                       S_AXI_AWREADY,
	input  wire logic [31:0]                S_AXI_WDATA,
	input  wire logic [3:0]                 S_AXI_WSTRB,
	input  wire logic                       S_AXI_WVALID,
	output wire logic                       S_AXI_WREADY,
	output      logic [1:0]                 S_AXI_BRESP,
	output      logic                       S_AXI_BVALID,
	input  wire logic                       S_AXI_BREADY,
	input  wire logic [7:0]                 S_AXI_ARADDR,
	input  wire logic                       S_AXI_ARVALID,
	output wire logic                       S_AXI_ARREADY,
	output      logic [31:0]                S_AXI_RDATA,
	output      logic [1:0]                 S_AXI_RRESP,
	output      logic                       S_AXI_RVALID,
	input  wire logic                       S_AXI_RREADY,
	input  wire logic [`IVU_NUM_FLAG-1:0]   EVT_FLAG,
	input  wire logic [`IVU_NUM_LEVEL-1:0]  EVT_LEVEL,
	input  wire ivu_seq_t                   SEQ,
	output      ivu_pcload_t                PC_LOAD,
	output      ivu_stk_t                   STACK,
	input  wire logic [7:0]                 STACK_RDATA,
	output wire logic                       CORE_HOLD,
	output      logic                       IRQ_TAKEN
);

	logic [7:0]                  status;
	logic [`IVU_NUM_FLAG-1:0]    flag_en;
	logic [`IVU_NUM_FLAG-1:0]    flags;
	logic [`IVU_NUM_LEVEL-1:0]   level_en;
	logic [15:0]                 sp;
	ivu_state_t                  state;
	logic [2:0]                  cnt;
	logic [2:0]                  entry_last;
	logic [3:0]                  vec_idx;
	logic [`IVU_PC_W-1:0]        ret_pc;
	logic [7:0]                  pop_hi;
	logic                        block;
	logic                        aw_held;
	logic                        w_held;
	logic [7:0]                  aw_addr;
	logic [31:0]                 w_data;
	logic [3:0]                  w_strb;

	// bus decode
	wire        wr_fire  = aw_held && w_held && !S_AXI_BVALID;
	wire        rd_fire  = S_AXI_ARVALID && S_AXI_ARREADY;
	wire [31:0] wmask    = {{8{w_strb[3]}}, {8{w_strb[2]}},
	                        {8{w_strb[1]}}, {8{w_strb[0]}}};
	wire        wr_stat  = wr_fire && aw_addr == `IVU_OFS_STATUS;
	wire        wr_fen   = wr_fire && aw_addr == `IVU_OFS_FLAG_EN;
	wire        wr_flag  = wr_fire && aw_addr == `IVU_OFS_FLAGS;
	wire        wr_len   = wr_fire && aw_addr == `IVU_OFS_LEVEL_EN;
	wire        wr_sp    = wr_fire && aw_addr == `IVU_OFS_STACK_PTR;
	wire        wr_info  = wr_fire && aw_addr == `IVU_OFS_INFO;
	wire        wr_map   = wr_stat | wr_fen | wr_flag | wr_len | wr_sp |
	                       wr_info;
	wire [31:0] wr_stat_v = ({24'h000000, status} & ~wmask) |
	                        (w_data & wmask);
	wire [31:0] wr_fen_v  = ({24'h000000, flag_en} & ~wmask) |
	                        (w_data & wmask);
	wire [31:0] wr_len_v  = ({28'h0000000, level_en} & ~wmask) |
	                        (w_data & wmask);
	wire [31:0] wr_sp_v   = ({16'h0000, sp} & ~wmask) | (w_data & wmask);
	wire [7:0]  sw_clr    = wr_flag ? (w_data[7:0] & wmask[7:0]) : 8'h00;

	assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
	assign S_AXI_WREADY  = !w_held && !S_AXI_BVALID;
	assign S_AXI_ARREADY = !S_AXI_RVALID;

	wire [7:0]  rd_a = S_AXI_ARADDR;
	wire        rd_map = rd_a == `IVU_OFS_STATUS || rd_a == `IVU_OFS_FLAG_EN ||
	                     rd_a == `IVU_OFS_FLAGS || rd_a == `IVU_OFS_LEVEL_EN ||
	                     rd_a == `IVU_OFS_STACK_PTR || rd_a == `IVU_OFS_INFO;
	wire [31:0] info_v = {22'h000000, block, state, vec_idx, cnt};
	wire [31:0] rd_v =
		(rd_a == `IVU_OFS_STATUS)    ? {24'h000000, status}   :
		(rd_a == `IVU_OFS_FLAG_EN)   ? {24'h000000, flag_en}  :
		(rd_a == `IVU_OFS_FLAGS)     ? {24'h000000, flags}    :
		(rd_a == `IVU_OFS_LEVEL_EN)  ? {28'h0000000, level_en} :
		(rd_a == `IVU_OFS_STACK_PTR) ? {16'h0000, sp}         :
		(rd_a == `IVU_OFS_INFO)      ? info_v                 : 32'h00000000;

	// requests and priority
	function automatic logic [3:0] ivu_first(input logic [11:0] r);
		logic [3:0] idx;
		idx = 4'h0;
		for (int i = `IVU_NUM_SRC - 1; i >= 0; i--) begin
			if (r[i]) begin
				idx = 4'(i);
			end
		end
		return idx;
	endfunction

	wire        gie      = status[`IVU_GIE_BIT];
	wire [11:0] req      = {EVT_LEVEL & level_en, flags & flag_en};
	wire [3:0]  sel_idx  = ivu_first(req);
	wire [11:0] sel_hot  = 12'h001 << sel_idx;
	wire        is_cli   = SEQ.boundary && SEQ.kind == IVU_INSN_CLI;
	wire        is_sei   = SEQ.boundary && SEQ.kind == IVU_INSN_SEI;
	wire        is_return_from_irq_instruction  = SEQ.boundary && SEQ.kind == IVU_INSN_RETURN_FROM_IRQ_INSTRUCTION;
	wire        gie_eff  = gie && !is_cli;
	wire        block_now = block && !SEQ.boundary;
	// entry only where an instruction has fully completed, or in sleep
	wire        at_point = (SEQ.boundary || SEQ.sleeping) && !is_return_from_irq_instruction;
	wire        take     = state == IVU_ST_IDLE && at_point && gie_eff &&
	                       !block_now && |req;
	wire        ret_go   = state == IVU_ST_IDLE && is_return_from_irq_instruction;
	wire        ret_done = state == IVU_ST_RETURN &&
	                       cnt == 3'(`IVU_RETURN_CYC - 1);
	wire [7:0]  hw_clr   = take ? sel_hot[7:0] : 8'h00;
	wire [7:0]  hw_clr_noevt = hw_clr & ~EVT_FLAG;
	wire        ent_push = state == IVU_ST_ENTRY &&
	                       cnt == 3'(`IVU_ENTRY_CYC - 3);

	assign CORE_HOLD = state != IVU_ST_IDLE;

	// status byte: hardware effects applied after software write
	wire [7:0] stat_sw = wr_stat ? wr_stat_v[7:0] : status;
	logic [7:0] next_status;
	always_comb begin
		next_status = stat_sw;
		if (take || is_cli) begin
			next_status[`IVU_GIE_BIT] = 1'b0;
		end else if (is_sei || ret_done) begin
			next_status[`IVU_GIE_BIT] = 1'b1;
		end
	end

	// set wins over both clears
	wire [7:0] next_flags = (flags & ~sw_clr & ~hw_clr) | EVT_FLAG;

	logic [15:0] next_sp;
	always_comb begin
		next_sp = wr_sp ? wr_sp_v[15:0] : sp;
		if (ent_push) begin
			next_sp = sp - `IVU_SP_STEP;
		end else if (ret_done) begin
			next_sp = sp + `IVU_SP_STEP;
		end
	end

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			status   <= `IVU_RST_STATUS;
			flag_en  <= `IVU_RST_FLAG_EN;
			flags    <= 8'h00;
			level_en <= `IVU_RST_LEVEL_EN;
			sp       <= `IVU_RST_STACK_PTR;
		end else begin
			status   <= next_status;
			flag_en  <= wr_fen ? wr_fen_v[7:0] : flag_en;
			flags    <= next_flags;
			level_en <= wr_len ? wr_len_v[3:0] : level_en;
			sp       <= next_sp;
		end
	end

	// sequence state
	logic [2:0] next_cnt;
	ivu_state_t next_state;
	always_comb begin
		next_state = state;
		next_cnt   = cnt + 3'h1;
		case (state)
			IVU_ST_IDLE: begin
				next_cnt = 3'h0;
				if (take) begin
					next_state = IVU_ST_ENTRY;
				end else if (ret_go) begin
					next_state = IVU_ST_RETURN;
				end
			end
			IVU_ST_ENTRY: begin
				if (cnt == entry_last) begin
					next_state = IVU_ST_JUMP;
					next_cnt   = 3'h0;
				end
			end
			IVU_ST_JUMP: begin
				if (cnt == 3'(`IVU_JUMP_CYC - 1)) begin
					next_state = IVU_ST_IDLE;
				end
			end
			IVU_ST_RETURN: begin
				if (ret_done) begin
					next_state = IVU_ST_IDLE;
				end
			end
			default: begin
				next_state = IVU_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			state <= IVU_ST_IDLE;
			cnt   <= 3'h0;
		end else begin
			state <= next_state;
			cnt   <= next_cnt;
		end
	end

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			entry_last <= 3'h0;
			vec_idx    <= 4'h0;
			ret_pc     <= 12'h000;
		end else if (take) begin
			entry_last <= SEQ.sleeping ?
			              3'(`IVU_ENTRY_CYC + `IVU_SLEEP_EXTRA_CYC - 1) :
			              3'(`IVU_ENTRY_CYC - 1);
			vec_idx    <= sel_idx;
			ret_pc     <= SEQ.next_pc;
		end
	end

	// one instruction must complete after enable or return
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			block <= 1'b0;
		end else if (is_sei || ret_done) begin
			block <= 1'b1;
		end else if (SEQ.boundary) begin
			block <= 1'b0;
		end
	end

	// stack port, reset vector load and vector load
	wire entry_lo  = state == IVU_ST_ENTRY && cnt == 3'h0;
	wire entry_hi  = state == IVU_ST_ENTRY && cnt == 3'h1;
	wire entry_end = state == IVU_ST_ENTRY && cnt == entry_last;
	wire pop_a     = state == IVU_ST_RETURN && cnt == 3'h0;
	wire pop_b     = state == IVU_ST_RETURN && cnt == 3'h1;
	wire pop_c     = state == IVU_ST_RETURN && cnt == 3'h2;

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			STACK     <= '0;
			pop_hi    <= 8'h00;
			PC_LOAD   <= '{valid: 1'b1, addr: `IVU_RESET_VECTOR};
			IRQ_TAKEN <= 1'b0;
		end else begin
			STACK.we    <= entry_lo || entry_hi;
			STACK.re    <= pop_a || pop_b;
			STACK.addr  <= entry_hi ? sp - 16'h0001 :
			               pop_a    ? sp + 16'h0001 :
			               pop_b    ? sp + `IVU_SP_STEP : sp;
			STACK.wdata <= entry_hi ? {4'h0, ret_pc[11:8]} : ret_pc[7:0];
			if (pop_c) begin
				pop_hi <= STACK_RDATA;
			end
			PC_LOAD.valid <= entry_end || ret_done;
			PC_LOAD.addr  <= ret_done ? {pop_hi[3:0], STACK_RDATA} :
			                 12'(vec_idx) + 12'h001;
			IRQ_TAKEN     <= take;
		end
	end

	// bus slave
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h00000000;
			w_strb  <= 4'h0;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_held <= 1'b1;
				aw_addr <= {S_AXI_AWADDR[7:2], 2'b00};
			end else if (wr_fire) begin
				aw_held <= 1'b0;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_held <= 1'b1;
				w_data <= S_AXI_WDATA;
				w_strb <= S_AXI_WSTRB;
			end else if (wr_fire) begin
				w_held <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP  <= `IVU_RESP_OKAY;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RRESP  <= `IVU_RESP_OKAY;
			S_AXI_RDATA  <= 32'h00000000;
		end else begin
			if (wr_fire) begin
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP  <= wr_map ? `IVU_RESP_OKAY : `IVU_RESP_SLVERR;
			end else if (S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
			if (rd_fire) begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA  <= rd_v;
				S_AXI_RRESP  <= rd_map ? `IVU_RESP_OKAY : `IVU_RESP_SLVERR;
			end else if (S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
			end
		end
	end

	// checks
	property p_gate;
		@(posedge CLOCK) disable iff (!RSTN)
		take |-> gie && !is_cli && (req & sel_hot) != 12'h000;
	endproperty
	a_gate: assert property (p_gate) else $error("take without enable");

	property p_prio;
		@(posedge CLOCK) disable iff (!RSTN)
		take |-> (req & (sel_hot - 12'h001)) == 12'h000;
	endproperty
	a_prio: assert property (p_prio) else $error("lower vector skipped");

	property p_gie_clr;
		@(posedge CLOCK) disable iff (!RSTN)
		take ##1 !wr_stat |-> !gie;
	endproperty
	a_gie_clr: assert property (p_gie_clr) else $error("enable kept");

	property p_return_from_irq_instruction;
		@(posedge CLOCK) disable iff (!RSTN)
		ret_go |-> (state == IVU_ST_IDLE) ##1
		           (state == IVU_ST_RETURN)[*4] ##1 (gie && PC_LOAD.valid &&
		           sp == $past(sp, 5) + `IVU_SP_STEP);
	endproperty
	a_return_from_irq_instruction: assert property (p_return_from_irq_instruction) else $error("bad return");

	property p_flag_clr;
		@(posedge CLOCK) disable iff (!RSTN)
		(|hw_clr_noevt) |=> (flags & $past(hw_clr_noevt)) == 8'h00;
	endproperty
	a_flag_clr: assert property (p_flag_clr) else $error("flag kept");

	property p_set_wins;
		@(posedge CLOCK) disable iff (!RSTN)
		(|EVT_FLAG) |=> (flags & $past(EVT_FLAG)) == $past(EVT_FLAG);
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost");

	property p_cli;
		@(posedge CLOCK) disable iff (!RSTN)
		is_cli |-> !take ##1 !gie;
	endproperty
	a_cli: assert property (p_cli) else $error("taken after disable");

	property p_after_en;
		@(posedge CLOCK) disable iff (!RSTN)
		(is_sei || ret_done) ##1 (!SEQ.boundary)[*1] |-> !take;
	endproperty
	a_after_en: assert property (p_after_en) else $error("too early");

	property p_entry;
		@(posedge CLOCK) disable iff (!RSTN)
		take && !SEQ.sleeping |=> (state == IVU_ST_ENTRY)[*4] ##1
		                          (state == IVU_ST_JUMP && PC_LOAD.valid);
	endproperty
	a_entry: assert property (p_entry) else $error("entry length");

	property p_jump;
		@(posedge CLOCK) disable iff (!RSTN)
		$rose(state == IVU_ST_JUMP) |-> (state == IVU_ST_JUMP)[*3] ##1
		                               (state == IVU_ST_IDLE);
	endproperty
	a_jump: assert property (p_jump) else $error("jump length");

	property p_sleep;
		@(posedge CLOCK) disable iff (!RSTN)
		take && SEQ.sleeping |=> (state == IVU_ST_ENTRY)[*8] ##1
		                         (state == IVU_ST_JUMP);
	endproperty
	a_sleep: assert property (p_sleep) else $error("wake length");

	property p_push;
		@(posedge CLOCK) disable iff (!RSTN)
		take && !wr_sp ##1 !wr_sp ##1 !wr_sp |=>
		sp == $past(sp, 3) - `IVU_SP_STEP;
	endproperty
	a_push: assert property (p_push) else $error("push step");

	c_take: cover property (@(posedge CLOCK) disable iff (!RSTN) take);
	c_wake: cover property (@(posedge CLOCK) disable iff (!RSTN)
	                        take && SEQ.sleeping);
	c_ret:  cover property (@(posedge CLOCK) disable iff (!RSTN) ret_done);
	c_nest: cover property (@(posedge CLOCK) disable iff (!RSTN)
	                        take && block == 1'b0 && sp != 16'h0000);

endmodule

// file: sim/ivu_stack_model.sv
// stack memory model standing beside the interrupt vectoring unit
// assumes the unit's clock; read data one cycle after a read strobe
`timescale 1ns/1ps

module ivu_stack_model
	import ivu_pkg::*;
(
	input  wire logic       CLOCK,
	input  wire ivu_stk_t   STACK,
	output      logic [7:0] STACK_RDATA
);
	logic [7:0] mem [0:65535];

	initial STACK_RDATA = 8'h00;

	always @(posedge CLOCK) begin
		if (STACK.we)
			mem[STACK.addr] <= STACK.wdata;
		// outside a read answer the held byte inverts every cycle
		if (STACK.re)
			STACK_RDATA <= mem[STACK.addr];
		else
			STACK_RDATA <= ~STACK_RDATA;
	end
endmodule

// file: sim/ivu_top_bench.sv
// self-checking bench of the interrupt vectoring unit
// assumes the stack model beside it; bench plays sequencer and sources
`timescale 1ns/1ps
`include "ivu_defines.svh"

module ivu_top_bench
	import ivu_pkg::*;
;
	typedef struct packed {
		logic [7:0]  a;
		logic [31:0] w;
		logic [31:0] r;
		logic [1:0]  resp;
	} ivu_row_t;

	logic        clock = 1'b0, rstn = 1'b0;
	logic [7:0]  awaddr = '0, araddr = '0, evt_flag = '0, stk_rdata;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = '0, rdata;
	logic [3:0]  wstrb = 4'hf, evt_level = '0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	ivu_seq_t    seq = '{1'b0, IVU_INSN_OTHER, 1'b0, 12'h123};
	ivu_pcload_t pc_load;
	ivu_stk_t    stack;
	logic        core_hold, irq_taken;
	int          error_cnt = 0, checked = 0;

	ivu_row_t rows [6] = '{
		'{`IVU_OFS_STATUS, 32'h7f, 32'h7f, `IVU_RESP_OKAY},
		'{`IVU_OFS_FLAG_EN, 32'ha5, 32'ha5, `IVU_RESP_OKAY},
		'{`IVU_OFS_LEVEL_EN, 32'hff, 32'h0f, `IVU_RESP_OKAY},
		'{`IVU_OFS_STACK_PTR, 32'hffff0100, 32'h0100, `IVU_RESP_OKAY},
		'{8'h18, 32'h55, 32'h0, `IVU_RESP_SLVERR},
		'{`IVU_OFS_FLAG_EN, 32'h06, 32'h06, `IVU_RESP_OKAY}};

	always #12.5 clock = ~clock;

	ivu_top dut_u (
		.CLOCK(clock), .RSTN(rstn),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
		.S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready), .EVT_FLAG(evt_flag),
		.EVT_LEVEL(evt_level), .SEQ(seq), .PC_LOAD(pc_load),
		.STACK(stack), .STACK_RDATA(stk_rdata),
		.CORE_HOLD(core_hold), .IRQ_TAKEN(irq_taken));

	ivu_stack_model stk_u (
		.CLOCK(clock), .STACK(stack), .STACK_RDATA(stk_rdata));

	task finish_test;
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		bit aw, w;
		aw = 0;
		w = 0;
		@(posedge clock);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge clock);
			if (awvalid && awready === 1'b1) begin
				aw = 1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready === 1'b1) begin
				w = 1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clock); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask

	task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clock); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clock); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk(nm, e, d);
	endtask

	task insn(input ivu_insn_t k);
		@(posedge clock);
		seq.boundary <= 1'b1;
		seq.kind <= k;
		@(posedge clock);
		seq.boundary <= 1'b0;
	endtask

	task evt(input logic [7:0] f);
		@(posedge clock);
		evt_flag <= f;
		@(posedge clock);
		evt_flag <= 8'h00;
	endtask

	task quiet(input int n);
		repeat (n) begin
			@(posedge clock);
			chk("no take", 32'h0, 32'(irq_taken | pc_load.valid));
		end
	endtask

	// cycles counted from the accepting edge to the pc load pulse
	task wait_pc(input logic [11:0] a, input int n_e, input logic tk,
			input int j_e);
		int   n, j;
		logic t;
		n = 0;
		j = 0;
		t = 1'b0;
		do begin
			@(posedge clock);
			n++;
			if (n == 1)
				t = irq_taken;
		end while (pc_load.valid !== 1'b1 && n < 40);
		chk("vector", 32'(a), 32'(pc_load.addr));
		chk("latency", n_e, n);
		chk("taken", 32'(tk), 32'(t));
		while (core_hold === 1'b1 && j < 9) begin
			j++;
			@(posedge clock);
		end
		chk("jump hold", j_e, j);
	endtask

	task note(input string s);
		$display("test %s done", s);
	endtask

	initial begin
		repeat (20000) @(posedge clock);
		error_cnt++;
		finish_test();
	end

	initial begin
		logic [31:0] d;
		logic [1:0]  rs;
		repeat (2) @(posedge clock);
		chk("reset vector", 32'h1000, 32'(pc_load));
		rstn <= 1'b1;
		// every register resets to zero
		for (int i = 0; i < 6; i++)
			rdc("reset value", 8'(i * 4), 32'h0);
		note("reset");
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w, rs);
			chk("bresp", 32'(rows[i].resp), 32'(rs));
			rd(rows[i].a, d, rs);
			chk("rdata", rows[i].r, d);
			chk("rresp", 32'(rows[i].resp), 32'(rs));
		end
		note("registers");
		evt(8'h07);
		insn(IVU_INSN_OTHER);
		quiet(6);
		rdc("flags", `IVU_OFS_FLAGS, 32'h07);
		wr(`IVU_OFS_FLAGS, 32'h0, rs);
		rdc("flags", `IVU_OFS_FLAGS, 32'h07);
		insn(IVU_INSN_SEI);
		quiet(6);
		insn(IVU_INSN_OTHER);
		wait_pc(12'h002, `IVU_ENTRY_CYC + 1, 1'b1, `IVU_JUMP_CYC);
		chk("push low", 32'h23, 32'(stk_u.mem[16'h0100]));
		chk("push high", 32'h01, 32'(stk_u.mem[16'h00ff]));
		rdc("sp", `IVU_OFS_STACK_PTR, 32'h00fe);
		rdc("status", `IVU_OFS_STATUS, 32'h7f);
		rdc("flags", `IVU_OFS_FLAGS, 32'h05);
		note("entry");
		insn(IVU_INSN_SEI);
		insn(IVU_INSN_OTHER);
		wait_pc(12'h003, `IVU_ENTRY_CYC + 1, 1'b1, `IVU_JUMP_CYC);
		rdc("sp", `IVU_OFS_STACK_PTR, 32'h00fc);
		insn(IVU_INSN_RETURN_FROM_IRQ_INSTRUCTION);
		wait_pc(12'h123, `IVU_RETURN_CYC + 1, 1'b0, 0);
		rdc("status", `IVU_OFS_STATUS, 32'hff);
		rdc("sp", `IVU_OFS_STACK_PTR, 32'h00fe);
		note("nesting");
		evt(8'h80);
		wr(`IVU_OFS_FLAGS, 32'h80, rs);
		rdc("flags", `IVU_OFS_FLAGS, 32'h01);
		wr(`IVU_OFS_FLAG_EN, 32'h07, rs);
		quiet(6);
		insn(IVU_INSN_CLI);
		quiet(6);
		rdc("status", `IVU_OFS_STATUS, 32'h7f);
		insn(IVU_INSN_RETURN_FROM_IRQ_INSTRUCTION);
		wait_pc(12'h123, `IVU_RETURN_CYC + 1, 1'b0, 0);
		quiet(6);
		insn(IVU_INSN_OTHER);
		wait_pc(12'h001, `IVU_ENTRY_CYC + 1, 1'b1, `IVU_JUMP_CYC);
		rd(`IVU_OFS_STATUS, d, rs);
		wr(`IVU_OFS_STATUS, d, rs);
		insn(IVU_INSN_RETURN_FROM_IRQ_INSTRUCTION);
		wait_pc(12'h123, `IVU_RETURN_CYC + 1, 1'b0, 0);
		note("disable and return");
		wr(`IVU_OFS_STATUS, 32'h0, rs);
		evt_level <= 4'h1;
		quiet(4);
		evt_level <= 4'h0;
		wr(`IVU_OFS_STATUS, 32'h80, rs);
		insn(IVU_INSN_OTHER);
		quiet(6);
		evt_level <= 4'h1;
		insn(IVU_INSN_OTHER);
		wait_pc(12'h009, `IVU_ENTRY_CYC + 1, 1'b1, `IVU_JUMP_CYC);
		evt_level <= 4'h0;
		insn(IVU_INSN_RETURN_FROM_IRQ_INSTRUCTION);
		wait_pc(12'h123, `IVU_RETURN_CYC + 1, 1'b0, 0);
		note("level");
		// one instruction after the return, else the wake stays blocked
		insn(IVU_INSN_OTHER);
		quiet(2);
		@(posedge clock);
		seq.sleeping <= 1'b1;
		evt_level <= 4'h1;
		@(posedge clock);
		seq.sleeping <= 1'b0;
		evt_level <= 4'h0;
		wait_pc(12'h009, `IVU_ENTRY_CYC + `IVU_SLEEP_EXTRA_CYC + 1, 1'b1,
			`IVU_JUMP_CYC);
		note("sleep");
		finish_test();
	end
endmodule
